// *** verilog/lfss_scheduler.v ***
// Summary of operation
// R1: interval field bits 7:4, read/write, sets spacing of detector power-ons.
// R2: writing the interval field restarts the interval on next oscillator tick.
// R3: reset loads interval field with 0110, i.e. 512 periods.
// R4: interval code 0000 or 1010 and above runs the detector continuously.
// R5: codes 0001 to 1001 give 16 to 4096 periods, doubling each step.
// R6: on-time field bits 3:0, read/write, sets detector on time per interval.
// R7: on time is net; 2 ms start-up sits in preceding off period.
// R8: carrier-detect mode powers down early once carrier evaluation completes.
// R9: data mode keeps detector on after detection until end, error or timeout.
// R10: reset clears the on-time field to zero.
// R11: on time counts whole oscillator cycles; shortest is one cycle.
// R12: software changes control only while disabled, waits two cycles to re-enable.
// R13: continuous mode stops after a good message, restarts after 2-3 periods.
// R14: mode select picks carrier-detect or data-receive operation.
// R15: interval counter runs only while enabled; power request opens each interval.
//
// Chosen here: the address map and the APB interface to the registers.

`include "lfss_map.vh"

module lfss_scheduler (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        slow_osc_clock,
  input  wire        receiver_enable,
  input  wire        detect_mode_sel,
  input  wire        signal_detected,
  input  wire        carrier_eval_done,
  input  wire        msg_end,
  input  wire        msg_error,
  input  wire        rx_timeout,
  input  wire        rx_success,
  output wire        det_power_on,
  output wire        det_on_window
);

  // ----------------------------------------
  // scheduler states
  // ----------------------------------------
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_WAIT = 3'h1;
  localparam [2:0] ST_SAMP = 3'h2;
  localparam [2:0] ST_CONT = 3'h3;
  localparam [2:0] ST_GAP  = 3'h4;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  reg  [3:0]  intv_sel_ff;
  reg  [3:0]  on_sel_ff;
  reg  [31:0] prdata_ff;
  reg         pready_ff;
  reg         pslverr_ff;
  reg         sosc_s1_ff;
  reg         sosc_s2_ff;
  reg         sosc_s3_ff;
  reg  [2:0]  state_ff;
  reg  [2:0]  nxt_state;
  reg  [12:0] cnt_ff;
  reg  [12:0] nxt_cnt;
  reg  [1:0]  gap_ff;
  reg  [1:0]  nxt_gap;
  reg         hold_ff;
  reg         nxt_hold;
  reg         early_ff;
  reg         nxt_early;
  reg         restart_ff;
  reg         power_ff;
  reg         nxt_power;
  reg         window_ff;
  reg         nxt_window;
  reg  [31:0] rd_mux;
  wire        osc_tick;
  wire        acc;
  wire        wr_ctl;
  wire        hit;
  wire        cont_mode;
  wire [3:0]  on_code;
  wire [12:0] period;
  wire [9:0]  on_len;
  wire        in_on;
  wire        in_startup;
  wire        ends_hold;

  // ----------------------------------------
  // apb slave
  // ----------------------------------------

  // access phase not yet answered; answer one cycle later
  assign acc    = psel & penable & ~pready_ff;
  assign hit    = (paddr == `LFSS_OFF_CTL) | (paddr == `LFSS_OFF_STAT);
  assign wr_ctl = acc & pwrite & (paddr == `LFSS_OFF_CTL);

  // read data selection
  always @* begin
    rd_mux = 32'h0000_0000;
    if (paddr == `LFSS_OFF_CTL) begin
      rd_mux[`LFSS_INTV_HI:`LFSS_INTV_LO] = intv_sel_ff;
      rd_mux[`LFSS_ONT_HI:`LFSS_ONT_LO]   = on_sel_ff;
    end else if (paddr == `LFSS_OFF_STAT) begin
      rd_mux[`LFSS_ST_PWR]   = power_ff;
      rd_mux[`LFSS_ST_WIN]   = window_ff;
      rd_mux[`LFSS_ST_HOLD]  = hold_ff;
      rd_mux[`LFSS_ST_EARLY] = early_ff;
      rd_mux[`LFSS_ST_STATE_HI:`LFSS_ST_STATE_LO] = state_ff;
      rd_mux[`LFSS_ST_CNT_HI:`LFSS_ST_CNT_LO]     = cnt_ff;
    end
  end

  // bus answer registers; unmapped access gets pslverr
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= acc;
      pslverr_ff <= acc & ~hit;
      if (acc & ~pwrite) begin
        prdata_ff <= rd_mux;
      end
    end
  end

  // ----------------------------------------
  // control register
  // ----------------------------------------

  // control fields; a write takes effect with the bus answer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // R3: interval reset value
      intv_sel_ff <= `LFSS_INTV_RST;
      // R10: on-time cleared
      on_sel_ff   <= `LFSS_ONT_RST;
    end else if (wr_ctl) begin
      // R1: interval field write
      intv_sel_ff <= pwdata[`LFSS_INTV_HI:`LFSS_INTV_LO];
      // R6: on-time field write
      on_sel_ff   <= pwdata[`LFSS_ONT_HI:`LFSS_ONT_LO];
    end
  end

  // pending restart after an interval write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      restart_ff <= 1'b0;
    end else if (wr_ctl) begin
      restart_ff <= 1'b1;
    end else if (osc_tick) begin
      restart_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // slow oscillator edge detect
  // ----------------------------------------

  // two-stage sync; third stage only feeds the edge detector
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sosc_s1_ff <= 1'b0;
      sosc_s2_ff <= 1'b0;
      sosc_s3_ff <= 1'b0;
    end else begin
      sosc_s1_ff <= slow_osc_clock;
      sosc_s2_ff <= sosc_s1_ff;
      sosc_s3_ff <= sosc_s2_ff;
    end
  end

  assign osc_tick = sosc_s2_ff & ~sosc_s3_ff;

  // ----------------------------------------
  // interval and on-time decode
  // ----------------------------------------

  // R4: continuous codes
  assign cont_mode = (intv_sel_ff == `LFSS_INTV_CONT) | (intv_sel_ff > `LFSS_INTV_MAX);

  // R5: period doubles per code, 16 at code 1
  assign period = `LFSS_BASE_PERIOD << intv_sel_ff;

  // codes above the top step hold the longest on time
  assign on_code = (on_sel_ff > `LFSS_ONT_MAX) ? `LFSS_ONT_MAX : on_sel_ff;

  // R11: whole cycles, one at minimum
  assign on_len = `LFSS_ONE_ON << on_code;

  // on window opens at count zero of each interval
  assign in_on = ({3'h0, on_len} > cnt_ff);

  // R7: start-up placed before the window
  // overlaps the window when the on time reaches into the last two counts of the period
  assign in_startup = (cnt_ff >= period - `LFSS_STARTUP_CYC);

  // R9: reasons to release the extension
  assign ends_hold = msg_end | msg_error | rx_timeout;

  // ----------------------------------------
  // scheduler next state
  // ----------------------------------------
  always @* begin
    nxt_state  = state_ff;
    nxt_cnt    = cnt_ff;
    nxt_gap    = gap_ff;
    nxt_hold   = hold_ff;
    nxt_early  = early_ff;
    nxt_power  = 1'b0;
    nxt_window = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        nxt_cnt   = 13'h0000;
        nxt_hold  = 1'b0;
        nxt_early = 1'b0;
        if (receiver_enable) begin
          nxt_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // R2: first interval on next tick
        if (osc_tick) begin
          nxt_cnt   = 13'h0000;
          nxt_early = 1'b0;
          nxt_state = cont_mode ? ST_CONT : ST_SAMP;
        end
      end
      ST_SAMP: begin
        // R15: interval counter while enabled
        if (osc_tick) begin
          if (cnt_ff >= period - 13'h0001) begin
            nxt_cnt   = 13'h0000;
            nxt_early = 1'b0;
          end else begin
            nxt_cnt = cnt_ff + 13'h0001;
          end
        end
        // R8: carrier evaluation ends window
        if (detect_mode_sel & carrier_eval_done & in_on) begin
          nxt_early = 1'b1;
        end
        // R9: data mode extends past window
        // window_ff too, so a hit on the last visible cycle is not lost
        if (~detect_mode_sel & signal_detected & (in_on | window_ff | hold_ff)) begin
          nxt_hold = 1'b1;
        end else if (ends_hold) begin
          nxt_hold = 1'b0;
        end
        // R15: power request at interval start
        nxt_window = (in_on & ~nxt_early) | nxt_hold;
        nxt_power  = nxt_window | in_startup;
      end
      ST_CONT: begin
        nxt_window = 1'b1;
        nxt_power  = 1'b1;
        // R13: stop after a good message
        if (rx_success) begin
          nxt_state  = ST_GAP;
          nxt_gap    = 2'h0;
          nxt_window = 1'b0;
          nxt_power  = 1'b0;
        end
      end
      ST_GAP: begin
        // R13: restart on third tick, 2-3 periods off
        if (osc_tick) begin
          if (gap_ff == `LFSS_GAP_CYC - 2'h1) begin
            nxt_state = ST_CONT;
          end else begin
            nxt_gap = gap_ff + 2'h1;
          end
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    // R2: interval rewrite restarts counting
    // wait already looks for the tick; forcing it again would change nothing
    if (restart_ff & (state_ff != ST_IDLE) & (state_ff != ST_WAIT)) begin
      nxt_hold   = 1'b0;
      nxt_early  = 1'b0;
      nxt_window = 1'b0;
      nxt_power  = 1'b0;
      if (osc_tick) begin
        // this tick is the one after the write, so start now
        nxt_cnt   = 13'h0000;
        nxt_state = cont_mode ? ST_CONT : ST_SAMP;
      end else begin
        nxt_state = ST_WAIT;
      end
    end
    // R15: disable stops everything
    if (~receiver_enable) begin
      nxt_state  = ST_IDLE;
      nxt_hold   = 1'b0;
      nxt_window = 1'b0;
      nxt_power  = 1'b0;
    end
  end

  // ----------------------------------------
  // scheduler registers
  // ----------------------------------------

  // outputs come straight from these flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff  <= ST_IDLE;
      cnt_ff    <= 13'h0000;
      gap_ff    <= 2'h0;
      hold_ff   <= 1'b0;
      early_ff  <= 1'b0;
      power_ff  <= 1'b0;
      window_ff <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      cnt_ff    <= nxt_cnt;
      gap_ff    <= nxt_gap;
      hold_ff   <= nxt_hold;
      early_ff  <= nxt_early;
      power_ff  <= nxt_power;
      window_ff <= nxt_window;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------

  // R14: mode select steers window shaping above
  assign det_power_on  = power_ff;
  assign det_on_window = window_ff;
  assign prdata        = prdata_ff;
  assign pready        = pready_ff;
  assign pslverr       = pslverr_ff;

endmodule // lfss_scheduler

// *** verilog/lfss_map.vh ***
`ifndef LFSS_MAP_VH
`define LFSS_MAP_VH

// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define LFSS_ADDR_W        12
`define LFSS_OFF_CTL       12'h000
`define LFSS_OFF_STAT      12'h004

// ----------------------------------------
// control register fields and reset values
// ----------------------------------------
`define LFSS_INTV_HI       7
`define LFSS_INTV_LO       4
`define LFSS_ONT_HI        3
`define LFSS_ONT_LO        0
`define LFSS_INTV_RST      4'h6
`define LFSS_ONT_RST       4'h0
`define LFSS_INTV_CONT     4'h0
`define LFSS_INTV_MAX      4'h9
`define LFSS_ONT_MAX       4'h9

// ----------------------------------------
// status register fields
// ----------------------------------------
`define LFSS_ST_PWR        0
`define LFSS_ST_WIN        1
`define LFSS_ST_HOLD       2
`define LFSS_ST_EARLY      3
`define LFSS_ST_STATE_HI   6
`define LFSS_ST_STATE_LO   4
`define LFSS_ST_CNT_HI     28
`define LFSS_ST_CNT_LO     16

// ----------------------------------------
// timing, in slow oscillator periods; LFSS_OSC_PERIOD_MS and LFSS_STARTUP_MS in ms
// ----------------------------------------
`define LFSS_OSC_PERIOD_MS 1
`define LFSS_STARTUP_MS    2
// start-up ms over oscillator period, sized to the interval counter
`define LFSS_STARTUP_CYC   13'h0002
// restart on the third tick, so the receiver stays off 2 to 3 periods
`define LFSS_GAP_CYC       2'h3
`define LFSS_BASE_PERIOD   13'h0008
`define LFSS_ONE_ON        10'h001
`define LFSS_CNT_W         13
`define LFSS_ON_W          10

`endif

// *** verification/lfss_sched_props.sv ***
module lfss_sched_props (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic        slow_osc_clock,
  input logic        receiver_enable,
  input logic        detect_mode_sel,
  input logic        signal_detected,
  input logic        carrier_eval_done,
  input logic        msg_end,
  input logic        msg_error,
  input logic        rx_timeout,
  input logic        rx_success,
  input logic        det_power_on,
  input logic        det_on_window
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------
  // control shadow
  // ------
  logic [7:0] ctl_ff;
  logic       wr_ff;
  wire        wr_tk = psel && penable && !pready && pwrite && paddr == 12'h000;
  wire        cont  = ctl_ff[7:4] == 4'h0 || ctl_ff[7:4] > 4'h9;
  wire        samp  = !cont;
  // a write restarts the schedule, so steady checks skip it
  wire        quiet = !wr_tk && !wr_ff && !rx_success && !carrier_eval_done;

  // word as written, taken on the first access edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_ff <= 8'h60;
      wr_ff  <= 1'b0;
    end else begin
      wr_ff <= wr_tk;
      if (wr_tk) begin
        ctl_ff <= pwdata[7:0];
      end
    end
  end

  // ------
  // properties
  // ------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // off, then back on within a few slow ticks
  sequence gap_s;
    !det_power_on ##[16:26] det_on_window;
  endsequence
  sequence held_s;
    det_power_on [*8];
  endsequence

  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than a cycle");
  slverr_map_a: assert property (pready |-> pslverr == (paddr != 12'h000 && paddr != 12'h004))
    else $error("pslverr wrong for address");
  ctl_read_a: assert property (pready && !pwrite && paddr == 12'h000 |->
    prdata == {24'h00_0000, ctl_ff}) else $error("control word read back wrong");
  disabled_off_a: assert property (!receiver_enable |=> !det_on_window && !det_power_on)
    else $error("detector on while disabled");
  cont_hold_a: assert property (cont && receiver_enable && det_on_window && quiet |=>
    det_on_window) else $error("continuous window dropped");
  success_gap_a: assert property (cont && receiver_enable && det_on_window && rx_success
    |=> gap_s) else $error("restart gap wrong");
  early_off_a: assert property (samp && detect_mode_sel && carrier_eval_done
    && det_on_window |-> ##[1:2] !det_on_window) else $error("carrier window not cut");
  hold_on_a: assert property (samp && !detect_mode_sel && signal_detected
    && det_on_window |=> held_s) else $error("data hold lost");
endmodule // lfss_sched_props

bind lfss_scheduler lfss_sched_props u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .slow_osc_clock(slow_osc_clock), .receiver_enable(receiver_enable),
  .detect_mode_sel(detect_mode_sel), .signal_detected(signal_detected),
  .carrier_eval_done(carrier_eval_done), .msg_end(msg_end), .msg_error(msg_error),
  .rx_timeout(rx_timeout), .rx_success(rx_success), .det_power_on(det_power_on),
  .det_on_window(det_on_window)
);

// *** verification/tb_top.sv ***
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin failures++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, ex, got); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, presetn, psel, penable, pwrite, osc, en, mode, sdet, ceval, rxok, err;
  logic [2:0]  ends, div_ff;
  logic [3:0]  on;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd, lf;
  wire  [31:0] prdata;
  wire         pready, pslverr, pwr, win;
  int          failures, cmp_count, n, hi, per, pw;

  lfss_scheduler uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .slow_osc_clock(osc), .receiver_enable(en), .detect_mode_sel(mode),
    .signal_detected(sdet), .carrier_eval_done(ceval), .msg_end(ends[0]),
    .msg_error(ends[1]), .rx_timeout(ends[2]), .rx_success(rxok),
    .det_power_on(pwr), .det_on_window(win)
  );

  // ------
  // helpers
  // ------
  function automatic logic [31:0] step(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // 16 ticks doubling per code, 8 pclk a tick
  function automatic int per_exp(input int iv);
    return 128 << (iv - 1);
  endfunction
  function automatic int on_exp(input int c);
    return 8 << c;
  endfunction

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // slow tick every 8 pclk keeps the long intervals affordable
  always @(posedge pclk) begin
    div_ff <= div_ff + 3'h1;
    osc    <= div_ff[2];
  end

  task automatic close_out(input logic to);
    if (to) failures++;
    $display("compared %0d, mismatched %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) close_out(1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // control changes only while disabled, with a settle gap
  task automatic arm(input logic [7:0] c);
    en <= 1'b0;
    cyc(20);
    apb(1'b1, 12'h000, {24'h00_0000, c});
    en <= 1'b1;
  endtask
  task automatic wait_win(input logic lvl, input int lim);
    n = 0;
    while (win !== lvl && n < lim) begin
      @(posedge pclk);
      n++;
    end
    if (win !== lvl) close_out(1'b1);
  endtask
  // cycles from one window rise to the next
  task automatic measure();
    logic seen0;
    {seen0, hi, pw, per} = '0;
    while (!(seen0 && win === 1'b1) && per < 5000) begin
      hi += (win === 1'b1);
      pw += (pwr === 1'b1);
      seen0 |= (win === 1'b0);
      @(posedge pclk);
      per++;
    end
  endtask

  // ------
  // main sequence
  // ------
  initial begin
    {presetn, psel, penable, pwrite, osc, en, mode, sdet, ceval, rxok} = '0;
    {ends, div_ff, on, paddr, pwdata, failures, cmp_count} = '0;
    lf = 32'h0001_1045;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    `CHK("ctl reset", 32'h0000_0060, rd)
    apb(1'b0, 12'h008, 32'h0);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h0000_0000, rd)
    $display("test reset done");
    repeat (8) begin
      lf = step(lf);
      apb(1'b1, 12'h000, lf);
      apb(1'b0, 12'h000, 32'h0);
      `CHK("ctl rw", {24'h00_0000, lf[7:0]}, rd)
    end
    $display("test register done");
    for (int iv = 1; iv <= 6; iv++) begin
      lf = step(lf);
      on = {2'b00, lf[1:0] % 2'd3};
      arm({iv[3:0], on});
      wait_win(1'b1, 40);
      `CHK("first interval", 1'b1, n <= 11)
      measure();
      `CHK("period", per_exp(iv), per)
      `CHK("on time", on_exp(on), hi)
      `CHK("start-up", on_exp(on) + 16, pw)
    end
    $display("test sampled done");
    for (int k = 0; k < 3; k++) begin
      arm(k == 0 ? 8'h00 : (k == 1 ? 8'ha0 : 8'hf0));
      wait_win(1'b1, 40);
      hi = 0;
      repeat (100) begin
        @(posedge pclk);
        hi += (win === 1'b1);
      end
      `CHK("continuous", 100, hi)
      rxok <= 1'b1;
      @(posedge pclk);
      rxok <= 1'b0;
      @(posedge pclk);
      `CHK("gap off", 1'b0, pwr)
      wait_win(1'b1, 60);
      `CHK("gap length", 1'b1, (n >= 16 && n <= 26))
    end
    $display("test continuous done");
    mode <= 1'b1;
    arm(8'h13);
    wait_win(1'b1, 40);
    cyc(5);
    ceval <= 1'b1;
    @(posedge pclk);
    ceval <= 1'b0;
    cyc(3);
    `CHK("early off", 1'b0, win)
    // data mode holds until each end cause
    mode <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      wait_win(1'b1, 200);
      sdet <= 1'b1;
      @(posedge pclk);
      sdet <= 1'b0;
      cyc(80);
      `CHK("held", 1'b1, pwr)
      ends[k] <= 1'b1;
      @(posedge pclk);
      ends[k] <= 1'b0;
      cyc(3);
      `CHK("released", 1'b0, pwr)
    end
    en <= 1'b0;
    cyc(40);
    `CHK("off power", 1'b0, pwr)
    `CHK("off window", 1'b0, win)
    apb(1'b0, 12'h004, 32'h0);
    `CHK("mapped err", 1'b0, err)
    `CHK("status idle", 32'h0000_0000, rd)
    $display("test modes done");
    close_out(1'b0);
  end
endmodule // tb_top
